/* core/dpe_ctrl.sv */
/*
 * Display prefetch enable control: APB register bank holding the
 * engine enable and shadow update bits, hardware set arbitration,
 * store row status, refresh and power-up monitoring.
 * Assumes synchronous inputs on pclk; presetn restarts the whole
 * display channel.
 */
// The address map and register access over APB are this design's own decisions.
// Notes on behaviour
// - enable set by hardware pulse or software
// - software write wins over hardware set
// - hardware set dropped on any control write
// - hardware set is one cycle, never retried
// - after a lost set, enable stays unsettable
// - short late frames lower effective refresh
// - power-up pause stalls fetch, corrupts data
`timescale 1ns/1ns
`default_nettype none

module dpe_ctrl import dpe_pkg::*; (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic hw_set_req,
    input wire logic line_done,
    input wire logic prod_frame_done,
    input wire logic disp_eof,
    input wire logic pd_power_on,
    output logic engine_enable,
    output logic shadow_update,
    output logic set_lost,
    output logic engine_stall,
    output logic refresh_drop
);

    ////////////////////////////////////////////////////////////////////
    // address decode

    function automatic logic is_ctrl(input logic [11:0] a);
        return a == OFF_CTRL;
    endfunction

    function automatic logic is_status(input logic [11:0] a);
        return a == OFF_STATUS;
    endfunction

    function automatic logic is_cfg(input logic [11:0] a);
        return a == OFF_CFG;
    endfunction

    function automatic logic is_drops(input logic [11:0] a);
        return a == OFF_DROPS;
    endfunction

    function automatic logic addr_ok(input logic [11:0] a);
        return is_ctrl(a) || is_status(a) || is_cfg(a) || is_drops(a);
    endfunction

    // saturating row step
    function automatic logic [7:0] sat_inc8(input logic [7:0] v);
        return (v == 8'hFF) ? v : v + 8'h01;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // declarations

    logic access;
    logic fire;
    logic wr_ctrl;
    logic wr_cfg;
    logic collide;
    logic hw_set_ok;
    logic sw_enable;
    logic short_frame;
    logic next_pready;
    logic next_pslverr;
    logic [31:0] next_prdata;
    logic next_engine_enable;
    logic next_shadow_update;
    logic next_set_lost;
    logic fetch_corrupt;
    logic next_fetch_corrupt;
    logic [7:0] line_cfg;
    logic [7:0] next_line_cfg;
    logic [7:0] store_row;
    logic [7:0] next_store_row;
    logic [15:0] drop_count;
    logic [31:0] status_word;

    ////////////////////////////////////////////////////////////////////
    // bus strobes

    assign access = psel && penable && !pready;
    assign fire = psel && penable && pready;
    assign wr_ctrl = fire && pwrite && is_ctrl(paddr);
    assign wr_cfg = fire && pwrite && is_cfg(paddr);
    assign collide = wr_ctrl && hw_set_req;
    // hardware set dropped on control write
    assign hw_set_ok = hw_set_req && !wr_ctrl && !set_lost;
    assign sw_enable = pwdata[CTRL_ENABLE] && !set_lost;
    assign short_frame = (line_cfg <= SHORT_LINES);

    always_comb begin
        status_word = 32'h00000000;
        status_word[ST_ENABLE] = engine_enable;
        status_word[ST_SHADOW] = shadow_update;
        status_word[ST_LOST] = set_lost;
        status_word[ST_CORRUPT] = fetch_corrupt;
        status_word[ST_STALL] = engine_stall;
        status_word[ST_ROW_LSB +: 8] = store_row;
    end

    ////////////////////////////////////////////////////////////////////
    // apb slave: one wait state, registered answer

    always_comb begin
        next_pready = access;
        next_pslverr = 1'b0;
        next_prdata = prdata;
        if (access) begin
            next_pslverr = !addr_ok(paddr);
            next_prdata = 32'h00000000;
            if (!pwrite) begin
                unique case (paddr)
                    OFF_CTRL: begin
                        next_prdata[CTRL_ENABLE] = engine_enable;
                        next_prdata[CTRL_SHADOW] = shadow_update;
                    end
                    OFF_STATUS: begin
                        next_prdata = status_word;
                    end
                    OFF_CFG: begin
                        next_prdata[7:0] = line_cfg;
                    end
                    OFF_DROPS: begin
                        next_prdata[15:0] = drop_count;
                    end
                    default: begin
                        next_prdata = 32'h00000000;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= RDATA_RST;
        end else begin
            pready <= next_pready;
            pslverr <= next_pslverr;
            prdata <= next_prdata;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // enable arbitration and control bits

    always_comb begin
        next_engine_enable = engine_enable;
        next_shadow_update = shadow_update;
        next_set_lost = set_lost;
        next_line_cfg = line_cfg;
        // lost set sticks until channel restart
        if (collide) begin
            next_set_lost = 1'b1;
        end
        if (wr_ctrl) begin
            next_engine_enable = sw_enable;
        end else if (hw_set_ok) begin
            next_engine_enable = 1'b1;
        end
        if (wr_ctrl && pwdata[CTRL_SHADOW]) begin
            next_shadow_update = 1'b1;
        end else if (disp_eof) begin
            next_shadow_update = 1'b0;
        end
        if (wr_cfg) begin
            next_line_cfg = pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            engine_enable <= 1'b0;
            shadow_update <= 1'b0;
            set_lost <= 1'b0;
            line_cfg <= CFG_LINES_RST;
        end else begin
            engine_enable <= next_engine_enable;
            shadow_update <= next_shadow_update;
            set_lost <= next_set_lost;
            line_cfg <= next_line_cfg;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // store row status and fetch corruption

    always_comb begin
        next_store_row = store_row;
        next_fetch_corrupt = fetch_corrupt;
        if (disp_eof) begin
            next_store_row = 8'h00;
        end else if (line_done && engine_enable) begin
            next_store_row = sat_inc8(store_row);
        end
        if (engine_stall && engine_enable) begin
            next_fetch_corrupt = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            store_row <= 8'h00;
            fetch_corrupt <= 1'b0;
        end else begin
            store_row <= next_store_row;
            fetch_corrupt <= next_fetch_corrupt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // monitors

    dpe_refresh_mon u_refresh (
        .pclk(pclk),
        .presetn(presetn),
        .active(engine_enable),
        .short_frame(short_frame),
        .prod_frame_done(prod_frame_done),
        .disp_eof(disp_eof),
        .refresh_drop(refresh_drop),
        .drop_count(drop_count)
    );

    dpe_pd_pause u_pause (
        .pclk(pclk),
        .presetn(presetn),
        .pd_power_on(pd_power_on),
        .engine_stall(engine_stall)
    );

endmodule // dpe_ctrl

`default_nettype wire

/* core/dpe_pkg.sv */
/*
 * Constants for the display prefetch enable control block: register
 * offsets, field positions, reset values and cycle counts.
 * Assumes a single 25 MHz prefetch clock and an APB register bus.
 */
package dpe_pkg;

    localparam int unsigned PCLK_HZ = 25000000;

    // register byte offsets
    localparam logic [11:0] OFF_CTRL = 12'h000;
    localparam logic [11:0] OFF_STATUS = 12'h004;
    localparam logic [11:0] OFF_CFG = 12'h008;
    localparam logic [11:0] OFF_DROPS = 12'h00C;

    // prefetch_control_reg fields
    localparam int unsigned CTRL_ENABLE = 0;
    localparam int unsigned CTRL_SHADOW = 1;

    // store_engine_status_reg fields
    localparam int unsigned ST_ENABLE = 0;
    localparam int unsigned ST_SHADOW = 1;
    localparam int unsigned ST_LOST = 2;
    localparam int unsigned ST_CORRUPT = 3;
    localparam int unsigned ST_STALL = 4;
    localparam int unsigned ST_ROW_LSB = 8;

    // input frame line count at or below which a frame counts as short
    localparam logic [7:0] SHORT_LINES = 8'h09;

    // cycles the engine clock stands still on graphics power-up
    localparam logic [3:0] PAUSE_CYCLES = 4'h8;

    // values after reset
    localparam logic [7:0] CFG_LINES_RST = 8'h00;
    localparam logic [15:0] DROPS_RST = 16'h0000;
    localparam logic [31:0] RDATA_RST = 32'h00000000;

endpackage

/* core/dpe_refresh_mon.sv */
/*
 * Refresh monitor: flags a display frame that repeats because the
 * producer did not finish a short frame in time, and counts them.
 * Assumes one-cycle pulses synchronous to pclk.
 */
`timescale 1ns/1ns
`default_nettype none

module dpe_refresh_mon import dpe_pkg::*; (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic active,
    input wire logic short_frame,
    input wire logic prod_frame_done,
    input wire logic disp_eof,
    output logic refresh_drop,
    output logic [15:0] drop_count
);

    logic pending;
    logic next_pending;
    logic next_refresh_drop;
    logic [15:0] next_drop_count;
    logic ready;

    ////////////////////////////////////////////////////////////////////
    // repeat short frame when producer late
    always_comb begin
        ready = pending | prod_frame_done;
        next_pending = pending;
        next_refresh_drop = 1'b0;
        next_drop_count = drop_count;
        if (disp_eof) begin
            next_pending = 1'b0;
            if (active && short_frame && !ready) begin
                next_refresh_drop = 1'b1;
                if (drop_count != 16'hFFFF) begin
                    next_drop_count = drop_count + 16'h0001;
                end
            end
        end else if (prod_frame_done) begin
            next_pending = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pending <= 1'b0;
            refresh_drop <= 1'b0;
            drop_count <= DROPS_RST;
        end else begin
            pending <= next_pending;
            refresh_drop <= next_refresh_drop;
            drop_count <= next_drop_count;
        end
    end

endmodule // dpe_refresh_mon

`default_nettype wire

/* core/dpe_pd_pause.sv */
/*
 * Power-up pause: on graphics power domain turn-on the engine clock
 * stands still for a fixed count; this marks that window as a stall.
 * Assumes pd_power_on is a one-cycle pulse synchronous to pclk.
 */
`timescale 1ns/1ns
`default_nettype none

module dpe_pd_pause import dpe_pkg::*; (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pd_power_on,
    output logic engine_stall
);

    logic [3:0] count;
    logic [3:0] next_count;
    logic next_engine_stall;

    ////////////////////////////////////////////////////////////////////
    // engine clock pause window
    always_comb begin
        next_count = count;
        if (pd_power_on) begin
            next_count = PAUSE_CYCLES;
        end else if (count != 4'h0) begin
            next_count = count - 4'h1;
        end
        next_engine_stall = (next_count != 4'h0);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count <= 4'h0;
            engine_stall <= 1'b0;
        end else begin
            count <= next_count;
            engine_stall <= next_engine_stall;
        end
    end

endmodule // dpe_pd_pause

`default_nettype wire

/* verif/dpe_disp_model.sv */
/* display unit model: frame timing, line and producer pulses.
   assumes pclk domain; slow holds back the producer's frames. */
`timescale 1ns/1ns
`default_nettype none
module dpe_disp_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic engine_enable,
    input wire logic slow,
    output logic line_done,
    output logic prod_frame_done,
    output logic disp_eof
);
    logic [3:0] cnt;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= 4'h0;
        end else begin
            cnt <= cnt + 4'h1;
        end
    end
    // lines only while engine enabled
    assign line_done = engine_enable && cnt[1:0] == 2'h3;
    assign prod_frame_done = !slow && cnt == 4'h7;
    assign disp_eof = cnt == 4'hF;
endmodule // dpe_disp_model
`default_nettype wire

/* verif/dpe_ctrl_sva.sv */
/* checker on the ports of dpe_ctrl.
   assumes a bind from the bench and the single pclk domain. */
`timescale 1ns/1ns
`default_nettype none
module dpe_ctrl_sva import dpe_pkg::*; (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic hw_set_req,
    input wire logic line_done,
    input wire logic prod_frame_done,
    input wire logic disp_eof,
    input wire logic pd_power_on,
    input wire logic engine_enable,
    input wire logic shadow_update,
    input wire logic set_lost,
    input wire logic engine_stall,
    input wire logic refresh_drop
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    logic wr_ctrl;
    assign wr_ctrl = psel && penable && pready && pwrite && paddr == OFF_CTRL;
    sequence s_coll;
        hw_set_req && wr_ctrl;
    endsequence
    sequence s_coll_zero;
        s_coll ##0 !pwdata[CTRL_ENABLE];
    endsequence
    property p_hw_set;
        hw_set_req && !wr_ctrl && !set_lost |=> engine_enable;
    endproperty
    property p_sw_wins;
        wr_ctrl && !set_lost |=> engine_enable == $past(pwdata[CTRL_ENABLE]);
    endproperty
    property p_discard;
        s_coll_zero |=> !engine_enable;
    endproperty
    property p_no_retry;
        s_coll_zero |=> !engine_enable [*3];
    endproperty
    property p_locked;
        set_lost && !engine_enable |=> set_lost && !engine_enable;
    endproperty
    property p_drop;
        refresh_drop |-> $past(disp_eof) && $past(engine_enable)
            ##1 !refresh_drop;
    endproperty
    property p_stall;
        pd_power_on |=> engine_stall [*8];
    endproperty
    property p_coll;
        s_coll |=> set_lost;
    endproperty
    a_hw_set: assert property (p_hw_set) else $error("hw set ignored");
    a_sw_wins: assert property (p_sw_wins) else $error("sw write lost");
    a_discard: assert property (p_discard) else $error("hw set kept");
    a_no_retry: assert property (p_no_retry) else $error("retried");
    a_locked: assert property (p_locked) else $error("lock left");
    a_drop: assert property (p_drop) else $error("bad drop pulse");
    a_stall: assert property (p_stall) else $error("stall short");
    a_coll: assert property (p_coll) else $error("no collision");
endmodule // dpe_ctrl_sva
`default_nettype wire

/* verif/testbench.sv */
/* directed bench for dpe_ctrl over apb with the display model.
   assumes dpe_pkg, the model and the checker compiled first. */
`timescale 1ns/1ns
`default_nettype none
module testbench import dpe_pkg::*;;
    logic pclk, presetn, psel, penable, pwrite, hw_pulse, coll, slow;
    logic pd_power_on, pready, pslverr, hw_set_req, line_done, err;
    logic prod_frame_done, disp_eof, engine_enable, shadow_update;
    logic set_lost, engine_stall, refresh_drop;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    int miscompares = 0;
    int check_count = 0;
    // collision pulse lands on the write's completing edge
    assign hw_set_req = hw_pulse | (coll & pready);
    dpe_ctrl u_dpe_ctrl (.pclk(pclk), .presetn(presetn), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .hw_set_req(hw_set_req), .line_done(line_done),
        .prod_frame_done(prod_frame_done), .disp_eof(disp_eof),
        .pd_power_on(pd_power_on), .engine_enable(engine_enable),
        .shadow_update(shadow_update), .set_lost(set_lost),
        .engine_stall(engine_stall), .refresh_drop(refresh_drop));
    dpe_disp_model u_dpe_disp_model (.pclk(pclk), .presetn(presetn),
        .engine_enable(engine_enable), .slow(slow), .line_done(line_done),
        .prod_frame_done(prod_frame_done), .disp_eof(disp_eof));
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    ////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        coll <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic rchk(input logic [11:0] a, input logic [31:0] m,
                        input logic [31:0] e);
        apb(1'b0, a, 32'h00000000);
        check(rd & m, e);
    endtask
    task automatic pulse_hw;
        hw_pulse <= 1'b1;
        @(posedge pclk);
        hw_pulse <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wait_eof;
        do @(posedge pclk); while (disp_eof !== 1'b1);
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////
    initial begin
        #200000;
        miscompares++;
        end_sim();
    end
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h00000000;
        hw_pulse = 1'b0;
        coll = 1'b0;
        slow = 1'b0;
        pd_power_on = 1'b0;
        presetn = 1'b0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rchk(OFF_CTRL, 32'hFFFFFFFF, 32'h00000000);
        rchk(OFF_CFG, 32'hFFFFFFFF, 32'h00000000);
        rchk(OFF_DROPS, 32'hFFFFFFFF, 32'h00000000);
        rchk(12'h010, 32'hFFFFFFFF, 32'h00000000);
        check({31'h0, err}, 32'h00000001);
        pulse_hw();
        check({31'h0, engine_enable}, 32'h00000001);
        apb(1'b1, OFF_CTRL, 32'h00000000);
        rchk(OFF_STATUS, 32'h00000001, 32'h00000000);
        apb(1'b1, OFF_CTRL, 32'h00000001);
        rchk(OFF_STATUS, 32'h00000001, 32'h00000001);
        rchk(OFF_STATUS, 32'h00000018, 32'h00000000);
        apb(1'b1, OFF_CFG, 32'h00000009);
        slow <= 1'b1;
        do @(posedge pclk); while (refresh_drop !== 1'b1);
        rchk(OFF_DROPS, 32'h0000FFFF, 32'h00000001);
        apb(1'b1, OFF_CFG, 32'h0000000A);
        wait_eof();
        wait_eof();
        rchk(OFF_DROPS, 32'h0000FFFF, 32'h00000001);
        slow <= 1'b0;
        wait_eof();
        rchk(OFF_STATUS, 32'h0000FF00, 32'h00000000);
        apb(1'b1, OFF_CTRL, 32'h00000003);
        check({31'h0, shadow_update}, 32'h00000001);
        rchk(OFF_STATUS, 32'h00000002, 32'h00000002);
        rchk(OFF_STATUS, 32'h0000FF00, 32'h00000300);
        wait_eof();
        rchk(OFF_STATUS, 32'h00000002, 32'h00000000);
        pd_power_on <= 1'b1;
        @(posedge pclk);
        pd_power_on <= 1'b0;
        @(posedge pclk);
        check({31'h0, engine_stall}, 32'h00000001);
        rchk(OFF_STATUS, 32'h00000018, 32'h00000018);
        apb(1'b1, OFF_CTRL, 32'h00000000);
        coll <= 1'b1;
        apb(1'b1, OFF_CTRL, 32'h00000002);
        check({31'h0, set_lost}, 32'h00000001);
        rchk(OFF_STATUS, 32'h00000005, 32'h00000004);
        apb(1'b1, OFF_CTRL, 32'h00000001);
        rchk(OFF_STATUS, 32'h00000001, 32'h00000000);
        pulse_hw();
        check({31'h0, engine_enable}, 32'h00000000);
        presetn <= 1'b0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rchk(OFF_STATUS, 32'h00000004, 32'h00000000);
        coll <= 1'b1;
        apb(1'b1, OFF_CTRL, 32'h00000001);
        rchk(OFF_STATUS, 32'h00000005, 32'h00000005);
        end_sim();
    end
endmodule // testbench
bind dpe_ctrl dpe_ctrl_sva u_dpe_ctrl_sva (.pclk(pclk), .presetn(presetn),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .hw_set_req(hw_set_req), .line_done(line_done),
    .prod_frame_done(prod_frame_done), .disp_eof(disp_eof),
    .pd_power_on(pd_power_on), .engine_enable(engine_enable),
    .shadow_update(shadow_update), .set_lost(set_lost),
    .engine_stall(engine_stall), .refresh_drop(refresh_drop));
`default_nettype wire
